// ### inc/cbiu_pkg.sv
// Constants, state codes and the control-block map of the bus controller unit.
// Assumes one system clock at twice the processor rate and a core that holds each request until answered.
// Notes on behaviour
// - Drive 20-bit address, strobes, status, write data
// - Capture local bus data during read cycles
// - Cycles take four clocks, ready stretches them
// - Hold request releases bus, grant answers it
// - Provide transceiver enable and direction outputs
// - Divide input clock by two for bus sequencing; answer and internal bus pulses last one input clock
// - Processor clock out is 50% duty reference
// - No instruction queue-status output mode offered
// - Peripheral register accesses use separate internal bus
// - Register block is 128 sixteen-bit registers
// - Block base relocatable, 256-byte aligned, mem/IO
package cbiu_pkg;
	// Register block geometry
	localparam int unsigned CBIU_BLOCK_REGS = 128;
	localparam int unsigned CBIU_BLOCK_BYTES = 256;
	// Relocation register offset inside the block (byte offset)
	localparam logic [7:0] CBIU_RELOC_OFFSET = 8'hA8;
	// Relocation register fields
	localparam int unsigned CBIU_RELOC_BASE_LSB = 0;
	localparam int unsigned CBIU_RELOC_BASE_W = 12;
	localparam int unsigned CBIU_RELOC_MEM_BIT = 12;
	// Reset value: base page 0x0FF, I/O space
	localparam logic [12:0] CBIU_RELOC_RESET = 13'h00FF;
	// Bus cycle status codes
	localparam logic [2:0] CBIU_ST_IO_READ = 3'h1;
	localparam logic [2:0] CBIU_ST_IO_WRITE = 3'h2;
	localparam logic [2:0] CBIU_ST_MEM_READ = 3'h5;
	localparam logic [2:0] CBIU_ST_MEM_WRITE = 3'h6;
	localparam logic [2:0] CBIU_ST_PASSIVE = 3'h7;
	// Bus sequencer states
	typedef enum logic [2:0] {
		CBIU_IDLE = 3'b000,
		CBIU_T1 = 3'b001,
		CBIU_T2 = 3'b010,
		CBIU_T3 = 3'b011,
		CBIU_TW = 3'b100,
		CBIU_T4 = 3'b101,
		CBIU_HOLD = 3'b110,
		CBIU_INT = 3'b111
	} cbiu_state_t;
endpackage

// ### src/cbiu_bus_controller_unit.sv
// Bus controller unit: local bus sequencer, bus sharing, clock halving and register block steering.
// Assumes inputs synchronous to clk_sys and a peripheral bus that answers read data within one processor clock.
`timescale 1ns/1ns
module cbiu_bus_controller_unit
	import cbiu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Core request side
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic reqIo,
	input wire logic [19:0] reqAddr,
	input wire logic [15:0] reqWData,
	output logic respValid,
	output logic [15:0] respRData,
	// Local bus
	output logic [15:0] adOut,
	output logic adOe,
	input wire logic [15:0] adIn,
	output logic [3:0] addrHigh,
	output logic addrLatch,
	output logic readStrobe_n,
	output logic writeStrobe_n,
	output logic [2:0] busStatus,
	output logic busCtrlOe,
	output logic transceiverEnable_n,
	output logic transceiverDirection,
	input wire logic ready,
	input wire logic holdReq,
	output logic busGrantOut,
	output logic processorClockOut,
	// Internal peripheral bus
	output logic [6:0] periphIndex,
	output logic [15:0] periphWData,
	output logic periphWrite,
	output logic periphRead,
	input wire logic [15:0] periphRData
);
	// Whole state of the unit
	typedef struct packed {
		cbiu_state_t state;
		logic processor_clock_out;
		logic respValid;
		logic [15:0] respData;
		logic [15:0] wdata;
		logic write;
		logic [15:0] adOut;
		logic adOe;
		logic [3:0] addrHigh;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic den_n;
		logic dtr;
		logic [2:0] status;
		logic ctrlOe;
		logic grant;
		logic [6:0] pIndex;
		logic [15:0] pWData;
		logic pWrite;
		logic pRead;
		logic [12:0] reloc;
	} cbiu_regs_t;

	cbiu_regs_t st_q;
	cbiu_regs_t st_d;
	logic tick; // End of a processor clock period
	logic hitBlock; // Request falls inside the register block
	logic [7:0] blockOffset; // Byte offset inside the block

	// Window match against the relocation register
	always_comb
	begin
		blockOffset = reqAddr[7:0];
		if (st_q.reloc[CBIU_RELOC_MEM_BIT])
		begin
			// Memory space: all 12 page bits compared
			hitBlock = !reqIo && (reqAddr[19:8] == st_q.reloc[CBIU_RELOC_BASE_LSB +: CBIU_RELOC_BASE_W]);
		end
		else
		begin
			// I/O space: 64K space, upper page bits zero
			hitBlock = reqIo && (reqAddr[19:16] == 4'h0)
				&& (reqAddr[15:8] == st_q.reloc[7:0]);
		end
	end

	// Half-rate phase; bus advances once per processor clock
	assign tick = st_q.processor_clock_out;

	// Next-state logic
	always_comb
	begin
		st_d = st_q;
		st_d.processor_clock_out = !st_q.processor_clock_out; // Toggle gives 50% duty
		st_d.respValid = 1'b0;
		st_d.pWrite = 1'b0;
		st_d.pRead = 1'b0;
		if (tick)
		begin
			case (st_q.state)
				CBIU_IDLE:
				begin
					if (holdReq)
					begin
						// Release the bus to another master
						st_d.state = CBIU_HOLD;
						st_d.grant = 1'b1;
						st_d.adOe = 1'b0;
						st_d.ctrlOe = 1'b0;
					end
					else if (reqValid && hitBlock)
					begin
						// Internal access, no external cycle
						st_d.state = CBIU_INT;
						st_d.pIndex = blockOffset[7:1];
						st_d.pWData = reqWData;
						st_d.write = reqWrite;
						if (blockOffset == CBIU_RELOC_OFFSET)
						begin
							// Relocation register handled locally
							if (reqWrite)
							begin
								st_d.reloc = reqWData[12:0];
							end
						end
						else
						begin
							st_d.pWrite = reqWrite;
							st_d.pRead = !reqWrite;
						end
					end
					else if (reqValid)
					begin
						// T1: address out, latch strobe, status
						st_d.state = CBIU_T1;
						st_d.wdata = reqWData;
						st_d.write = reqWrite;
						st_d.adOut = reqAddr[15:0];
						st_d.adOe = 1'b1;
						st_d.addrHigh = reqAddr[19:16];
						st_d.ale = 1'b1;
						st_d.dtr = reqWrite;
						if (reqIo)
						begin
							st_d.status = reqWrite ? CBIU_ST_IO_WRITE : CBIU_ST_IO_READ;
						end
						else
						begin
							st_d.status = reqWrite ? CBIU_ST_MEM_WRITE : CBIU_ST_MEM_READ;
						end
					end
				end
				CBIU_T1:
				begin
					// T2: data phase, strobes and transceiver on
					st_d.state = CBIU_T2;
					st_d.ale = 1'b0;
					st_d.den_n = 1'b0;
					if (st_q.write)
					begin
						st_d.adOut = st_q.wdata;
						st_d.wr_n = 1'b0;
					end
					else
					begin
						st_d.adOe = 1'b0;
						st_d.rd_n = 1'b0;
					end
				end
				CBIU_T2:
				begin
					st_d.state = CBIU_T3;
				end
				CBIU_T3, CBIU_TW:
				begin
					if (ready)
					begin
						// Ready seen: finish the cycle
						st_d.state = CBIU_T4;
						if (!st_q.write)
						begin
							st_d.respData = adIn;
						end
						st_d.rd_n = 1'b1;
						st_d.wr_n = 1'b1;
						st_d.den_n = 1'b1;
						st_d.status = CBIU_ST_PASSIVE;
					end
					else
					begin
						// Wait state while ready is low
						st_d.state = CBIU_TW;
					end
				end
				CBIU_T4:
				begin
					// Cycle complete, answer the core
					st_d.state = CBIU_IDLE;
					st_d.respValid = 1'b1;
					st_d.adOe = 1'b0;
					st_d.dtr = 1'b0;
				end
				CBIU_HOLD:
				begin
					if (!holdReq)
					begin
						// Request withdrawn: take the bus back
						st_d.state = CBIU_IDLE;
						st_d.grant = 1'b0;
						st_d.ctrlOe = 1'b1;
					end
				end
				CBIU_INT:
				begin
					// Peripheral data returned one processor clock later
					st_d.state = CBIU_IDLE;
					st_d.respValid = 1'b1;
					if (!st_q.write)
					begin
						st_d.respData = (st_q.pIndex == CBIU_RELOC_OFFSET[7:1])
							? {3'h0, st_q.reloc} : periphRData;
					end
				end
				default:
				begin
					st_d.state = CBIU_IDLE;
				end
			endcase
		end
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
			st_q.state <= CBIU_IDLE;
			st_q.rd_n <= 1'b1;
			st_q.wr_n <= 1'b1;
			st_q.den_n <= 1'b1;
			st_q.status <= CBIU_ST_PASSIVE;
			st_q.ctrlOe <= 1'b1;
			st_q.reloc <= CBIU_RELOC_RESET;
		end
		else if (ce)
		begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register; no queue-status pins exist
	assign respValid = st_q.respValid;
	assign respRData = st_q.respData;
	assign adOut = st_q.adOut;
	assign adOe = st_q.adOe;
	assign addrHigh = st_q.addrHigh;
	assign addrLatch = st_q.ale;
	assign readStrobe_n = st_q.rd_n;
	assign writeStrobe_n = st_q.wr_n;
	assign busStatus = st_q.status;
	assign busCtrlOe = st_q.ctrlOe;
	assign transceiverEnable_n = st_q.den_n;
	assign transceiverDirection = st_q.dtr;
	assign busGrantOut = st_q.grant;
	assign processorClockOut = st_q.processor_clock_out;
	assign periphIndex = st_q.pIndex;
	assign periphWData = st_q.pWData;
	assign periphWrite = st_q.pWrite;
	assign periphRead = st_q.pRead;
endmodule

// ### tb/cbiu_assertions.sv
// Checker of bus cycle timing at the bus controller unit ports.
// Assumes binding to that unit by port name.
`timescale 1ns/1ns
module cbiu_checker import cbiu_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic ready,
	input wire logic holdReq,
	input wire logic addrLatch,
	input wire logic adOe,
	input wire logic readStrobe_n,
	input wire logic writeStrobe_n,
	input wire logic busCtrlOe,
	input wire logic transceiverEnable_n,
	input wire logic transceiverDirection,
	input wire logic busGrantOut,
	input wire logic processorClockOut,
	input wire logic respValid,
	input wire logic [2:0] busStatus
);
	wire tick = processorClockOut && ce; // Processor tick edge
	wire strobing = !readStrobe_n || !writeStrobe_n; // Data phase
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Address phase opens a cycle
	sequence addrPhase; $rose(addrLatch); endsequence
	// Tick late in the data phase
	sequence lateTick; tick && strobing && $past(strobing, 3); endsequence
	clk_half_a: assert property (ce |=> processorClockOut != $past(processorClockOut))
		else $error("clock out stuck");
	addr_phase_a: assert property (addrPhase |-> busStatus[1:0] == {transceiverDirection, !transceiverDirection}
		##1 addrLatch ##1 !addrLatch && strobing) else $error("address phase");
	min_cycle_a: assert property ($rose(strobing) |-> strobing[*4])
		else $error("cycle short");
	wait_hold_a: assert property (lateTick ##0 !ready |=> strobing)
		else $error("wait ignored");
	ready_end_a: assert property (lateTick ##0 ready |=> !strobing)
		else $error("ready ignored");
	resp_done_a: assert property ($fell(strobing) |-> busStatus == CBIU_ST_PASSIVE ##2 respValid)
		else $error("no answer");
	xcvr_dir_a: assert property (strobing |-> !transceiverEnable_n && transceiverDirection == !writeStrobe_n)
		else $error("transceiver");
	grant_hold_a: assert property ($rose(busGrantOut) |-> $past(holdReq) && !busCtrlOe && !adOe)
		else $error("grant");
	release_bus_a: assert property (busGrantOut && tick && !holdReq |=> !busGrantOut && busCtrlOe)
		else $error("release");
endmodule
bind cbiu_bus_controller_unit cbiu_checker chk (.*);

// ### tb/cbiu_bus_memory.sv
// Local bus memory of 16 words with a settable ready delay.
// Assumes the bus pins of the bus controller unit on the same clock.
`timescale 1ns/1ns
module cbiu_bus_memory (
	input wire logic clk_sys,
	input wire logic addrLatch,
	input wire logic adOe,
	input wire logic readStrobe_n,
	input wire logic writeStrobe_n,
	input wire logic [15:0] adOut,
	input wire logic [2:0] waitTicks,
	output logic [15:0] adIn,
	output logic ready
);
	logic [15:0] mem[16]; // Word storage
	logic [15:0] junk = 16'h5A5A; // Floating bus pattern
	logic [3:0] addr; // Latched word address
	logic [3:0] cnt = 4'h0; // Clocks into the data phase
	// Wire level: controller, memory in a read, else a changing pattern
	assign adIn = adOe ? adOut : (!readStrobe_n ? mem[addr] : junk);
	// Ready after the chosen extra ticks
	assign ready = cnt >= 4'(2 * waitTicks + 3);
	always @(posedge clk_sys)
	begin
		junk <= ~junk;
		cnt <= (readStrobe_n && writeStrobe_n) ? 4'h0 : cnt + 4'h1;
		if (addrLatch) addr <= adOut[4:1];
		if (!writeStrobe_n) mem[addr] <= adOut;
	end
endmodule

// ### tb/test_core_bus_interface_unit.sv
// Bench: core requests to a local bus memory, a second master and the register block.
// Assumes the unit, its bound checker and the memory model.
`timescale 1ns/1ns
module test_core_bus_interface_unit import cbiu_pkg::*;;
	logic clk_sys = 0, rst_n = 0, ce = 1, reqValid = 0, reqWrite = 0, reqIo = 0, holdReq = 0;
	logic [19:0] reqAddr = '0;
	logic [15:0] reqWData = '0, d[4];
	logic [2:0] waitTicks = '0;
	logic respValid, addrLatch, adOe, readStrobe_n, writeStrobe_n, busCtrlOe, transceiverEnable_n;
	logic transceiverDirection, ready, busGrantOut, processorClockOut, periphWrite, periphRead;
	logic [15:0] respRData, adOut, adIn, periphWData;
	logic [3:0] addrHigh;
	logic [2:0] busStatus;
	logic [6:0] periphIndex;
	logic [16:0] expQ[$]; // Notes: read flag and word
	int fail_count = 0, compares = 0, i;
	int pulses = 0; // Internal bus strobes seen
	logic [19:0] expAddr = '0; // Address of the last request
	logic [15:0] expWData = '0; // Write data of the last request
	logic [2:0] expStat = '0; // Status the last request should show
	logic expW = 1'b0; // Last request was a write
	wire logic [15:0] periphRData = {9'h155, periphIndex}; // Registers echo their index
	cbiu_bus_controller_unit uut (.*);
	cbiu_bus_memory mem (.*);
	always #25 clk_sys = ~clk_sys;
	// Compare one value
	task automatic check(input logic [15:0] seen, want);
		compares++;
		if (seen !== want)
		begin
			fail_count++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// Report and end
	task automatic stop_test(input bit hung);
		if (hung) fail_count++;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One request, held until answered
	task automatic txn(input logic w, io, input logic [19:0] a, input logic [15:0] wd, ed);
		int n;
		n = 0;
		expAddr = a;
		expW = w;
		expWData = wd;
		expStat = io ? (w ? CBIU_ST_IO_WRITE : CBIU_ST_IO_READ) : (w ? CBIU_ST_MEM_WRITE : CBIU_ST_MEM_READ);
		expQ.push_back({!w, ed});
		{reqWrite, reqIo, reqAddr, reqWData, reqValid} = {w, io, a, wd, 1'b1};
		while (respValid !== 1'b1)
		begin
			@(negedge clk_sys);
			n++;
			if (n > 60) stop_test(1'b1);
		end
		reqValid = 1'b0;
		@(negedge clk_sys);
	endtask
	// Oldest note against each answer
	always @(posedge clk_sys)
	begin
		if (respValid === 1'b1)
		begin
			check(16'(expQ.size() > 0), 16'h0001);
			if (expQ.size() > 0)
			begin
				if (expQ[0][16]) check(respRData, expQ[0][15:0]);
				void'(expQ.pop_front());
			end
		end
	end
	// Address phase and internal strobes against the pending request
	always @(posedge clk_sys)
	begin
		if (addrLatch === 1'b1)
		begin
			check(adOut, expAddr[15:0]);
			check({12'h000, addrHigh}, {12'h000, expAddr[19:16]});
			check({13'h0000, busStatus}, {13'h0000, expStat});
		end
		if (periphRead === 1'b1 || periphWrite === 1'b1)
		begin
			pulses++;
			check({9'h000, periphIndex}, {9'h000, expAddr[7:1]});
			check({15'h0000, periphWrite}, {15'h0000, expW});
			if (periphWrite === 1'b1) check(periphWData, expWData);
		end
	end
	initial
	begin
		void'($urandom(32'h53712270));
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		txn(1'b0, 1'b1, 20'h0FFA8, 16'h0000, 16'h00FF);
		// Clock enable low freezes the divider
		ce = 1'b0;
		d[0] = {15'h0000, processorClockOut};
		repeat (5) @(negedge clk_sys);
		check({15'h0000, processorClockOut}, d[0]);
		ce = 1'b1;
		// Writes then reads, random data and ready delay
		for (i = 0; i < 8; i++)
		begin
			waitTicks = 3'($urandom % 4);
			if (i < 4) d[i] = 16'($urandom);
			txn(i < 4, 1'b0, 20'h10000 + 20'(2 * (i % 4)), d[i % 4], d[i % 4]);
		end
		// Second master holds the bus while a write waits
		holdReq = 1'b1;
		fork
			txn(1'b1, 1'b0, 20'h10000, 16'hC3C3, 16'h0000);
			begin
				repeat (6) @(negedge clk_sys);
				check({15'h0000, busGrantOut}, 16'h0001);
				check({busCtrlOe, respValid, 14'h0000}, 16'h0000);
				holdReq = 1'b0;
			end
		join
		// Block moved to memory page 123h
		txn(1'b1, 1'b1, 20'h0FFA8, 16'h1123, 16'h0000);
		txn(1'b0, 1'b0, 20'h123A8, 16'h0000, 16'h1123);
		txn(1'b0, 1'b0, 20'h12300, 16'h0000, 16'hAA80);
		txn(1'b0, 1'b0, 20'h123FE, 16'h0000, 16'hAAFF);
		// Internal write with random data
		d[1] = 16'($urandom);
		txn(1'b1, 1'b0, 20'h12320, d[1], 16'h0000);
		txn(1'b0, 1'b0, 20'h12400, 16'h0000, 16'hC3C3);
		// Reset in mid-run returns the block to I/O page FFh
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		txn(1'b0, 1'b1, 20'h0FFA8, 16'h0000, 16'h00FF);
		check(16'(pulses), 16'h0003);
		check(16'(expQ.size()), 16'h0000);
		stop_test(1'b0);
	end
endmodule
